// [src/ssim_defines.svh]
// register offsets, field positions and reset values of the serial
// interface status and interrupt mask block
// assumes an 8-bit byte address on a 32-bit APB data path
`ifndef SSIM_DEFINES_SVH
`define SSIM_DEFINES_SVH

// ==========================================================
// register offsets
`define SSIM_OFF_CTRL 8'h00
`define SSIM_OFF_MODE 8'h04
`define SSIM_OFF_RX_HOLD 8'h08
`define SSIM_OFF_TX_HOLD 8'h0C
`define SSIM_OFF_STATUS 8'h10
`define SSIM_OFF_IRQ_SET 8'h14
`define SSIM_OFF_IRQ_CLR 8'h18
`define SSIM_OFF_IRQ_VIEW 8'h1C

// ==========================================================
// shared flag layout
`define SSIM_BIT_RX_FULL 0
`define SSIM_BIT_TX_EMPTY 1
`define SSIM_BIT_MODE_FAULT 2
`define SSIM_BIT_OVERRUN 3
`define SSIM_BIT_RX_DMA 4
`define SSIM_BIT_TX_DMA 5
`define SSIM_BIT_ENABLE_STATE 16

// ==========================================================
// control and mode fields
`define SSIM_BIT_CMD_ENABLE 0
`define SSIM_BIT_CMD_DISABLE 1
`define SSIM_BIT_CMD_SWRST 7
`define SSIM_BIT_MODE_MASTER 0

// ==========================================================
// reset values
`define SSIM_RST_FLAGS 6'h00
`define SSIM_RST_MASK 6'h00
`define SSIM_RST_WORD 16'h0000

`endif

// [src/ssim_pkg.sv]
// types shared by the status and interrupt mask block and its bench
// assumes the defines header supplies all numeric constants
package ssim_pkg;

    // ==========================================================
    // one bit per interrupt source, in the shared layout
    typedef logic [5:0] ssim_flags_t;

    // ==========================================================
    // APB request and answer
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } ssim_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } ssim_apb_rsp_t;

endpackage

// [src/ssim_status_irq.sv]
// status flags, interrupt mask and APB register file of a serial
// peripheral interface controller
// assumes a shifter on the same clock that pulses tx_load and rx_load;
// the chip-select pin arrives asynchronously and is synchronised here
//
// Behaviour
// - A write to the transmit holding register clears transmit-empty until the word moves to the shifter.
// - Transmit-empty sets once the last written word has moved into the shifter.
// - Transmit-empty reads zero after reset and while the interface is disabled.
// - The enable command sets transmit-empty to one.
// - A detected mode fault latches its flag until a status read clears it.
// - Overrun is flagged when the receive holding register is loaded again before it was read.
// - Overrun stays set until a status read, then reads zero until a new overrun.
// - The receive-DMA-done bit follows the receive end-of-transfer level.
// - The transmit-DMA-done bit follows the transmit end-of-transfer level.
// - The enable-state bit reads one while enabled and zero while disabled.
// - Writing one to an enable-set bit sets that mask bit; zeros change nothing.
// - Writing one to an enable-clear bit clears that mask bit; zeros change nothing.
// - The mask view shows one per enabled source and resets to zero.
// - Status, enable-set, enable-clear and mask share the six-bit layout.
// - Receive-full sets on a load from the shifter and clears on a holding register read.
`timescale 1ns/100ps

`include "ssim_defines.svh"

module ssim_status_irq
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register bus
    input wire ssim_pkg::ssim_apb_req_t apb_req,
    output ssim_pkg::ssim_apb_rsp_t apb_rsp,
    // shifter side
    input wire logic tx_load,
    input wire logic rx_load,
    input wire logic [15:0] rx_word,
    output logic [15:0] tx_word,
    output logic tx_word_pending,
    output logic master_mode,
    output logic enabled,
    // pins and dma channels
    input wire logic cs0_pin_n,
    input wire logic rx_dma_end,
    input wire logic tx_dma_end,
    // interrupt
    output logic irq
);
    import ssim_pkg::*;

    // ==========================================================
    // declarations
    logic cs_meta_q;
    logic cs_sync_q;
    logic enable_q;
    logic master_q;
    logic tx_empty_q;
    logic rx_full_q;
    logic rx_stale_q;
    logic mode_fault_q;
    logic overrun_q;
    ssim_flags_t mask_q;
    logic [15:0] tx_word_q;
    logic [15:0] rx_word_q;
    logic [31:0] prdata_q;
    logic pslverr_q;
    logic [31:0] rd_value;
    logic rd_mapped;
    ssim_flags_t status_now;
    logic setup_rd;
    logic acc;
    logic acc_wr;
    logic acc_rd;
    logic sw_reset;
    logic cmd_enable;
    logic cmd_disable;
    logic wr_tx_hold;
    logic rd_rx_hold;
    logic rd_status;
    logic fault_seen;
    logic [31:0] wdata;
    logic [7:0] addr;

    // ==========================================================
    // bus decode
    assign addr = apb_req.paddr;
    assign wdata = apb_req.pwdata;
    assign setup_rd = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
    // zero wait states: every access phase completes at its first edge
    assign acc = apb_req.psel && apb_req.penable;
    assign acc_wr = acc && apb_req.pwrite;
    assign acc_rd = acc && !apb_req.pwrite;
    assign sw_reset = acc_wr && (addr == `SSIM_OFF_CTRL)
        && wdata[`SSIM_BIT_CMD_SWRST];
    // disable wins when both command bits are written together
    assign cmd_disable = acc_wr && (addr == `SSIM_OFF_CTRL)
        && wdata[`SSIM_BIT_CMD_DISABLE];
    assign cmd_enable = acc_wr && (addr == `SSIM_OFF_CTRL)
        && wdata[`SSIM_BIT_CMD_ENABLE] && !cmd_disable;
    assign wr_tx_hold = acc_wr && (addr == `SSIM_OFF_TX_HOLD);
    assign rd_rx_hold = acc_rd && (addr == `SSIM_OFF_RX_HOLD);
    assign rd_status = acc_rd && (addr == `SSIM_OFF_STATUS);

    // ==========================================================
    // status word in the shared layout
    always_comb
    begin
        status_now = `SSIM_RST_FLAGS;
        status_now[`SSIM_BIT_RX_FULL] = rx_full_q;
        status_now[`SSIM_BIT_TX_EMPTY] = tx_empty_q && enable_q;
        status_now[`SSIM_BIT_MODE_FAULT] = mode_fault_q;
        status_now[`SSIM_BIT_OVERRUN] = overrun_q;
        status_now[`SSIM_BIT_RX_DMA] = rx_dma_end;
        status_now[`SSIM_BIT_TX_DMA] = tx_dma_end;
    end

    always_comb
    begin
        rd_value = 32'h0000_0000;
        rd_mapped = 1'b1;
        case (addr)
            `SSIM_OFF_CTRL, `SSIM_OFF_TX_HOLD,
            `SSIM_OFF_IRQ_SET, `SSIM_OFF_IRQ_CLR:
                rd_value = 32'h0000_0000;
            `SSIM_OFF_MODE:
                rd_value[`SSIM_BIT_MODE_MASTER] = master_q;
            `SSIM_OFF_RX_HOLD:
                rd_value[15:0] = rx_word_q;
            `SSIM_OFF_STATUS:
            begin
                rd_value[5:0] = status_now;
                rd_value[`SSIM_BIT_ENABLE_STATE] = enable_q;
            end
            `SSIM_OFF_IRQ_VIEW:
                rd_value[5:0] = mask_q;
            default:
                rd_mapped = 1'b0;
        endcase
    end

    // ==========================================================
    // read data and error are captured in the setup phase
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end
        else if (apb_req.psel && !apb_req.penable)
        begin
            prdata_q <= setup_rd ? rd_value : 32'h0000_0000;
            pslverr_q <= !rd_mapped;
        end
    end

    // one driver for the whole answer word
    assign apb_rsp = '{
        prdata: prdata_q,
        pready: 1'b1,
        pslverr: pslverr_q && acc
    };

    // ==========================================================
    // chip-select pin synchroniser
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cs_meta_q <= 1'b1;
            cs_sync_q <= 1'b1;
        end
        else
        begin
            cs_meta_q <= cs0_pin_n;
            cs_sync_q <= cs_meta_q;
        end
    end

    // another master pulling our own select low while we are master
    assign fault_seen = master_q && !cs_sync_q;

    // ==========================================================
    // enable and mode
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            enable_q <= 1'b0;
        else if (sw_reset || cmd_disable)
            enable_q <= 1'b0;
        else if (cmd_enable)
            enable_q <= 1'b1;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            master_q <= 1'b0;
        else if (sw_reset)
            master_q <= 1'b0;
        else if (acc_wr && addr == `SSIM_OFF_MODE)
            master_q <= wdata[`SSIM_BIT_MODE_MASTER];
    end

    // ==========================================================
    // transmit holding register and its empty flag
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            tx_word_q <= `SSIM_RST_WORD;
        else if (sw_reset)
            tx_word_q <= `SSIM_RST_WORD;
        else if (wr_tx_hold)
            tx_word_q <= wdata[15:0];
    end

    // a write in the same cycle as a load keeps the flag low: the new
    // word is the one still waiting for the shifter
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            tx_empty_q <= 1'b0;
        else if (sw_reset || cmd_disable)
            tx_empty_q <= 1'b0;
        else if (cmd_enable)
            tx_empty_q <= 1'b1;
        else if (wr_tx_hold)
            tx_empty_q <= 1'b0;
        else if (tx_load && enable_q)
            tx_empty_q <= 1'b1;
    end

    assign tx_word = tx_word_q;
    assign tx_word_pending = enable_q && !tx_empty_q;

    // ==========================================================
    // receive holding register, full and overrun flags
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rx_word_q <= `SSIM_RST_WORD;
        else if (sw_reset)
            rx_word_q <= `SSIM_RST_WORD;
        else if (rx_load)
            rx_word_q <= rx_word;
    end

    // a load at the setup edge means the access returns the older word,
    // so that read must not clear receive-full for the new one
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rx_stale_q <= 1'b0;
        else if (apb_req.psel && !apb_req.penable)
            rx_stale_q <= rx_load;
    end

    // a load wins over a read at the same edge
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rx_full_q <= 1'b0;
        else if (sw_reset)
            rx_full_q <= 1'b0;
        else if (rx_load)
            rx_full_q <= 1'b1;
        else if (rd_rx_hold && !rx_stale_q)
            rx_full_q <= 1'b0;
    end

    // only bits returned by the read are cleared, so an event landing
    // between setup and access phase is never lost
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            overrun_q <= 1'b0;
        else if (sw_reset)
            overrun_q <= 1'b0;
        else if (rx_load && rx_full_q && !rd_rx_hold)
            overrun_q <= 1'b1;
        else if (rd_status && prdata_q[`SSIM_BIT_OVERRUN])
            overrun_q <= 1'b0;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            mode_fault_q <= 1'b0;
        else if (sw_reset)
            mode_fault_q <= 1'b0;
        else if (fault_seen)
            mode_fault_q <= 1'b1;
        else if (rd_status && prdata_q[`SSIM_BIT_MODE_FAULT])
            mode_fault_q <= 1'b0;
    end

    // ==========================================================
    // interrupt mask
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            mask_q <= `SSIM_RST_MASK;
        else if (sw_reset)
            mask_q <= `SSIM_RST_MASK;
        else if (acc_wr && addr == `SSIM_OFF_IRQ_SET)
            mask_q <= mask_q | wdata[5:0];
        else if (acc_wr && addr == `SSIM_OFF_IRQ_CLR)
            mask_q <= mask_q & ~wdata[5:0];
    end

    assign irq = |(status_now & mask_q);
    assign master_mode = master_q;
    assign enabled = enable_q;

    // ==========================================================
    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_tx_write_clear: assert property (
        wr_tx_hold && !cmd_enable |=> !status_now[`SSIM_BIT_TX_EMPTY]
    ) else $error("transmit-empty not cleared by holding write");

    a_tx_load_set: assert property (
        tx_load && enable_q && !wr_tx_hold && !cmd_disable && !sw_reset
        |=> status_now[`SSIM_BIT_TX_EMPTY]
    ) else $error("transmit-empty not set after shifter load");

    a_tx_off_zero: assert property (
        !enable_q |-> !tx_empty_q
    ) else $error("transmit-empty high while disabled");

    a_enable_sets: assert property (
        cmd_enable && !sw_reset |=> tx_empty_q && enable_q
    ) else $error("enable command did not set transmit-empty");

    a_fault_latch: assert property (
        fault_seen && !sw_reset |=> mode_fault_q
    ) else $error("mode fault not latched");

    a_fault_hold: assert property (
        mode_fault_q && !rd_status && !sw_reset |=> mode_fault_q
    ) else $error("mode fault lost before status read");

    a_overrun_set: assert property (
        rx_load && rx_full_q && !rd_rx_hold && !sw_reset |=> overrun_q
    ) else $error("overrun not flagged");

    a_overrun_clear: assert property (
        rd_status && prdata_q[`SSIM_BIT_OVERRUN] && !rx_load
        |=> !overrun_q
    ) else $error("overrun not cleared by status read");

    a_enable_view: assert property (
        $rose(enable_q) |-> $past(cmd_enable)
    ) else $error("enable state rose without command");

    a_mask_set: assert property (
        acc_wr && addr == `SSIM_OFF_IRQ_SET && !sw_reset
        |=> (mask_q & $past(wdata[5:0])) == $past(wdata[5:0])
    ) else $error("mask bits not set");

    a_mask_clear: assert property (
        acc_wr && addr == `SSIM_OFF_IRQ_CLR
        |=> (mask_q & $past(wdata[5:0])) == 6'h00
    ) else $error("mask bits not cleared");

    a_rx_full_set: assert property (
        rx_load && !sw_reset |=> status_now[`SSIM_BIT_RX_FULL]
    ) else $error("receive-full not set on load");

    a_irq_level: assert property (
        mask_q == 6'h00 |-> !irq
    ) else $error("interrupt with all sources masked");

    a_irq_tx_source: assert property (
        enable_q && tx_empty_q && mask_q[`SSIM_BIT_TX_EMPTY] |-> irq
    ) else $error("unmasked transmit-empty without interrupt");

endmodule

// [verification/ssim_status_irq_tb_top.sv]
// self-checking bench for the status flags and interrupt mask block
// assumes the design, its package and the defines header compile first
`timescale 1ns/100ps

`include "ssim_defines.svh"

module ssim_status_irq_tb_top;
    import ssim_pkg::*;

    // ==========================================================
    // design signals and bench state
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    ssim_apb_req_t apb_req = '0;
    ssim_apb_rsp_t apb_rsp;
    logic tx_load = 1'b0;
    logic rx_load = 1'b0;
    logic [15:0] rx_word = 16'h0000;
    logic [15:0] tx_word;
    logic tx_word_pending;
    logic master_mode;
    logic enabled;
    logic cs0_pin_n = 1'b1;
    logic rx_dma_end = 1'b0;
    logic tx_dma_end = 1'b0;
    logic irq;
    int num_errors = 0;
    int tests_run = 0;
    int cycles = 0;
    logic [31:0] r;
    logic e;
    logic [15:0] w1;
    logic [15:0] w2;
    logic [5:0] s;
    logic [5:0] c;
    logic [5:0] mask_m;
    logic rxd;
    logic txd;

    always #50 clk = ~clk;

    ssim_status_irq dut (
        .clk(clk),
        .rst_n(rst_n),
        .apb_req(apb_req),
        .apb_rsp(apb_rsp),
        .tx_load(tx_load),
        .rx_load(rx_load),
        .rx_word(rx_word),
        .tx_word(tx_word),
        .tx_word_pending(tx_word_pending),
        .master_mode(master_mode),
        .enabled(enabled),
        .cs0_pin_n(cs0_pin_n),
        .rx_dma_end(rx_dma_end),
        .tx_dma_end(tx_dma_end),
        .irq(irq)
    );

    // ==========================================================
    // helpers
    task automatic finish_test();
        $display("errors %0d of checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // the request is held until pready is seen high at a rising edge
    task automatic apb(input logic wr_en, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] rdata,
                       output logic err);
        @(posedge clk);
        apb_req.psel <= 1'b1;
        apb_req.penable <= 1'b0;
        apb_req.pwrite <= wr_en;
        apb_req.paddr <= a;
        apb_req.pwdata <= d;
        @(posedge clk);
        apb_req.penable <= 1'b1;
        // no cycle limit: if pready never rises, only the bench timeout ends this wait
        do
            @(posedge clk);
        while (apb_rsp.pready !== 1'b1);
        rdata = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rr;
        logic ee;
        apb(1'b1, a, d, rr, ee);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] rr);
        logic ee;
        apb(1'b0, a, 32'h0, rr, ee);
    endtask

    // flags are {tx_dma, rx_dma, overrun, mode_fault, tx_empty, rx_full}
    function automatic logic [31:0] sts(input logic en, input logic [5:0] f);
        return {15'h0000, en, 10'h000, f};
    endfunction

    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            num_errors++;
            finish_test();
        end
    end

    // ==========================================================
    // main sequence
    initial
    begin
        void'($urandom(66489));
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rd(`SSIM_OFF_IRQ_VIEW, r);
        check(r, 32'h0);
        // the view is read-only: a write must not reach the mask
        wr(`SSIM_OFF_IRQ_VIEW, 32'h0000003F);
        rd(`SSIM_OFF_IRQ_VIEW, r);
        check(r, 32'h0);
        rd(`SSIM_OFF_STATUS, r);
        check(r, sts(1'b0, 6'h00));
        apb(1'b0, 8'h40, 32'h0, r, e);
        check({31'h0, e}, 32'h1);
        check({31'h0, irq}, 32'h0);
        wr(`SSIM_OFF_CTRL, 32'h1);
        rd(`SSIM_OFF_STATUS, r);
        check(r, sts(1'b1, 6'h02));
        w1 = 16'($urandom);
        wr(`SSIM_OFF_TX_HOLD, {16'h0, w1});
        // outputs launched at the access edge are settled by the falling one
        @(negedge clk);
        check({16'h0, tx_word}, {16'h0, w1});
        check({31'h0, tx_word_pending}, 32'h1);
        rd(`SSIM_OFF_STATUS, r);
        check(r, sts(1'b1, 6'h00));
        @(posedge clk);
        tx_load <= 1'b1;
        @(posedge clk);
        tx_load <= 1'b0;
        rd(`SSIM_OFF_STATUS, r);
        check(r, sts(1'b1, 6'h02));
        check({31'h0, tx_word_pending}, 32'h0);
        // two loads back to back with no read between them
        w1 = 16'($urandom);
        w2 = 16'($urandom);
        @(posedge clk);
        rx_load <= 1'b1;
        rx_word <= w1;
        @(posedge clk);
        rx_word <= w2;
        @(posedge clk);
        rx_load <= 1'b0;
        rd(`SSIM_OFF_STATUS, r);
        check(r, sts(1'b1, 6'h0B));
        rd(`SSIM_OFF_STATUS, r);
        check(r, sts(1'b1, 6'h03));
        rd(`SSIM_OFF_RX_HOLD, r);
        check(r, {16'h0, w2});
        rd(`SSIM_OFF_STATUS, r);
        check(r, sts(1'b1, 6'h02));
        wr(`SSIM_OFF_MODE, 32'h1);
        @(negedge clk);
        check({31'h0, master_mode}, 32'h1);
        rd(`SSIM_OFF_MODE, r);
        check(r, 32'h1);
        @(posedge clk);
        cs0_pin_n <= 1'b0;
        repeat (5) @(posedge clk);
        cs0_pin_n <= 1'b1;
        repeat (5) @(posedge clk);
        rd(`SSIM_OFF_STATUS, r);
        check(r, sts(1'b1, 6'h06));
        rd(`SSIM_OFF_STATUS, r);
        check(r, sts(1'b1, 6'h02));
        mask_m = 6'h00;
        repeat (40)
        begin
            @(posedge clk);
            rxd = 1'($urandom);
            txd = 1'($urandom);
            rx_dma_end <= rxd;
            tx_dma_end <= txd;
            s = 6'($urandom);
            c = 6'($urandom);
            wr(`SSIM_OFF_IRQ_SET, {26'h0, s});
            wr(`SSIM_OFF_IRQ_CLR, {26'h0, c});
            mask_m = (mask_m | s) & ~c;
            rd(`SSIM_OFF_IRQ_VIEW, r);
            check(r, {26'h0, mask_m});
            rd(`SSIM_OFF_STATUS, r);
            check(r, sts(1'b1, {txd, rxd, 4'h2}));
            @(negedge clk);
            check({31'h0, irq}, {31'h0, |(mask_m & {txd, rxd, 4'h2})});
        end
        wr(`SSIM_OFF_CTRL, 32'h2);
        rd(`SSIM_OFF_STATUS, r);
        check(r, sts(1'b0, {txd, rxd, 4'h0}));
        // enable and disable together leave the interface disabled
        wr(`SSIM_OFF_CTRL, 32'h3);
        @(negedge clk);
        check({31'h0, enabled}, 32'h0);
        // soft reset must drop a full mask and the master bit
        wr(`SSIM_OFF_IRQ_SET, 32'h0000003F);
        wr(`SSIM_OFF_CTRL, 32'h80);
        @(negedge clk);
        check({31'h0, master_mode}, 32'h0);
        rd(`SSIM_OFF_IRQ_VIEW, r);
        check(r, 32'h0);
        finish_test();
    end

endmodule
